// ---- ssrl_top.sv ----
// Status reporting and service request logic of the measurement instrument
// Functional notes
// R1: Subrange n reached sets bit n-1
// R2: Bit 14 flags changeover hold point
// R3: Bits 10-13 unused, bit 15 zero
// R4: Hold pauses sweep until continue command
// R5: Service request on enabled bits 2,3,4,5,7
// R6: Summary bits reflect enabled source state
// R7: Controller should enable all request sources
// R8: Enable bit 0 selects operation complete
// R9: Status bit 5 summarises standard events
// R10: Service request is sole own-initiative activity
// R11: Serial poll returns the status byte
// R12: Poll bit is OR of enable AND status
// R13: Drive poll bit on allocated line only
// R14: Store poll line and inversion setting
// R15: Individual status query returns poll bit
// R16: Controller loads equal request and poll enables
// R17: Every status part readable as bit pattern
// R18: Every error appends one queue entry
// R19: Error query pops one; empty gives zero
// R20: Controller should read errors after requests
// R21: Request holds while enabled condition persists
// R22: Full error queue discards new errors
`timescale 1ns/1ps
module ssrl_top #(
    parameter int ERRQ_DEPTH = 8
) (
    input wire logic I_CLOCK,
    input wire logic I_RESET,
    input wire logic I_CMD_VALID,
    input wire logic [ssrl_pkg::CMD_W-1:0] I_CMD_CODE,
    input wire logic [ssrl_pkg::DATA_W-1:0] I_CMD_DATA,
    output logic O_RESP_VALID,
    output logic [ssrl_pkg::DATA_W-1:0] O_RESP_DATA,
    input wire logic I_ERR_VALID,
    input wire logic I_ERR_IS_CMD,
    input wire logic [ssrl_pkg::CODE_W-1:0] I_ERR_CODE,
    input wire logic I_SUBRANGE_VALID,
    input wire logic [ssrl_pkg::RANGE_NUM_W-1:0] I_SUBRANGE_NUM,
    input wire logic I_CHANGEOVER,
    output logic O_SWEEP_HOLD,
    output logic O_SWEEP_RESUME,
    input wire logic I_OPS_DONE,
    input wire logic I_OUT_AVAIL,
    input wire logic I_OPER_SUMMARY,
    input wire logic I_SPOLL_REQ,
    output logic O_SPOLL_VALID,
    output logic [ssrl_pkg::STB_W-1:0] O_SPOLL_BYTE,
    input wire logic I_PPOLL_PIN,
    output logic O_SRQ_OUT,
    output logic O_SRQ_OE,
    output logic [ssrl_pkg::STB_W-1:0] O_DIO_OUT,
    output logic [ssrl_pkg::STB_W-1:0] O_DIO_OE
);

    // ********************************
    // Declarations
    // ********************************
    ssrl_errq_if errq ();

    logic [7:0] sre_r, sre_nxt, ese_r, ese_nxt, ppe_r, ppe_nxt, esr_r, esr_nxt;
    logic [4:0] ppc_r, ppc_nxt;
    logic [9:0] range_r, range_nxt;
    logic [15:0] tevt_r, tevt_nxt, tena_r, tena_nxt;
    logic opc_arm_r, opc_arm_nxt;
    ssrl_pkg::ssrl_sweep_t sweep_r, sweep_nxt;
    logic resume_r, resume_nxt;
    logic resp_valid_r, resp_valid_nxt;
    logic [15:0] resp_data_r, resp_data_nxt;
    logic spoll_valid_r, spoll_valid_nxt;
    logic [7:0] spoll_byte_r, spoll_byte_nxt;

    ssrl_pkg::ssrl_cmd_t cmd;
    logic [15:0] tcond;
    logic [15:0] tevt_set;
    logic [7:0] esr_set;
    logic [7:0] stb_base;
    logic [7:0] stb;
    logic rqs;
    logic ist;
    logic range_ok;

    // Any bit set in both vectors
    function automatic logic summary(input logic [15:0] a, input logic [15:0] b);
        summary = |(a & b);
    endfunction

    // Zero-extend a byte register into the reply word
    function automatic logic [15:0] widen(input logic [7:0] v);
        widen = {8'h00, v};
    endfunction

    // ********************************
    // Submodules
    // ********************************
    ssrl_errq #(.DEPTH(ERRQ_DEPTH)) u_errq (
        .clk(I_CLOCK),
        .rst(I_RESET),
        .q(errq)
    );

    ssrl_poll u_poll (
        .clk(I_CLOCK),
        .rst(I_RESET),
        .ppoll_pin(I_PPOLL_PIN),
        .stb(stb),
        .ppe(ppe_r),
        .line(ppc_r[ssrl_pkg::LINE_W-1:0]),
        .invert(ppc_r[ssrl_pkg::PPC_SENSE_BIT]),
        .enable(ppc_r[ssrl_pkg::PPC_ENA_BIT]),
        .ist(ist),
        .dio_out(O_DIO_OUT),
        .dio_oe(O_DIO_OE)
    );

    // Every reported error is pushed to the queue, command faults included
    assign errq.push = I_ERR_VALID; // R18
    assign errq.push_code = I_ERR_CODE;
    assign errq.pop = I_CMD_VALID && (cmd == ssrl_pkg::CMD_ERR_Q); // R19

    // ********************************
    // Status byte and service request
    // ********************************
    assign cmd = ssrl_pkg::ssrl_cmd_t'(I_CMD_CODE);
    // Condition view: current range, hold point, unused bits and bit 15 zero
    assign tcond = {1'b0, (sweep_r == ssrl_pkg::SWEEP_HOLD), 4'h0, range_r}; // R2 R3

    // Queue, message and operation bits pass as is; questionable and event bits are gated by their enable part
    always_comb begin
        stb_base = ssrl_pkg::BYTE_RESET;
        stb_base[ssrl_pkg::STB_ERRQ] = !errq.empty; // R6
        stb_base[ssrl_pkg::STB_QUES] = summary(tevt_r, tena_r); // R6
        stb_base[ssrl_pkg::STB_MAV] = I_OUT_AVAIL; // R6
        stb_base[ssrl_pkg::STB_ESB] = summary(widen(esr_r), widen(ese_r)); // R9
        stb_base[ssrl_pkg::STB_OPER] = I_OPER_SUMMARY; // R6
        rqs = summary(widen(stb_base & ssrl_pkg::SRQ_SOURCE_MASK), widen(sre_r)); // R5 R21
        stb = stb_base;
        stb[ssrl_pkg::STB_RQS] = rqs;
    end

    // Open-drain request line, pulled only while a source stays enabled and set
    assign O_SRQ_OUT = 1'b0;
    assign O_SRQ_OE = rqs; // R10 R21

    // ********************************
    // Event capture
    // ********************************
    // Hardware sets win over read-clear in the same cycle
    always_comb begin
        range_ok = (I_SUBRANGE_NUM >= ssrl_pkg::RANGE_FIRST) && (I_SUBRANGE_NUM <= ssrl_pkg::RANGE_LAST);
        tevt_set = ssrl_pkg::WORD_RESET;
        if (I_SUBRANGE_VALID && range_ok) begin
            tevt_set[I_SUBRANGE_NUM - ssrl_pkg::RANGE_FIRST] = 1'b1; // R1
        end
        if (sweep_r == ssrl_pkg::SWEEP_RUN && I_CHANGEOVER) begin
            tevt_set[ssrl_pkg::TRAN_HOLD_BIT] = 1'b1; // R2
        end
        esr_set = ssrl_pkg::BYTE_RESET;
        esr_set[ssrl_pkg::ESR_OPC] = opc_arm_r && I_OPS_DONE; // R8
        esr_set[ssrl_pkg::ESR_CME] = I_ERR_VALID && I_ERR_IS_CMD; // R18
        esr_set[ssrl_pkg::ESR_DDE] = I_ERR_VALID && !I_ERR_IS_CMD; // R18
    end

    // ********************************
    // Register, sweep and reply next state
    // ********************************
    always_comb begin
        sre_nxt = sre_r;
        ese_nxt = ese_r;
        ppe_nxt = ppe_r;
        ppc_nxt = ppc_r;
        tena_nxt = tena_r;
        esr_nxt = esr_r | esr_set;
        tevt_nxt = tevt_r | tevt_set;
        range_nxt = range_r;
        opc_arm_nxt = opc_arm_r && !I_OPS_DONE;
        sweep_nxt = sweep_r;
        resume_nxt = 1'b0;
        resp_valid_nxt = 1'b0;
        resp_data_nxt = resp_data_r;
        spoll_valid_nxt = I_SPOLL_REQ;
        spoll_byte_nxt = I_SPOLL_REQ ? stb : spoll_byte_r; // R11
        // Latest subrange replaces the previous one in the condition view
        if (I_SUBRANGE_VALID && range_ok) begin
            range_nxt = tevt_set[ssrl_pkg::TRAN_RANGES-1:0]; // R1
        end
        // Sweep pauses at the changeover until the continue command
        unique case (sweep_r)
            ssrl_pkg::SWEEP_RUN: begin
                if (I_CHANGEOVER) begin
                    sweep_nxt = ssrl_pkg::SWEEP_HOLD; // R4
                end
            end
            ssrl_pkg::SWEEP_HOLD: begin
                if (I_CMD_VALID && cmd == ssrl_pkg::CMD_CONT) begin
                    sweep_nxt = ssrl_pkg::SWEEP_RUN; // R4
                    resume_nxt = 1'b1;
                end
            end
        endcase
        if (I_CMD_VALID) begin
            resp_valid_nxt = 1'b1;
            resp_data_nxt = ssrl_pkg::WORD_RESET;
            // Replies carry the register's bit pattern as a plain number
            case (cmd)
                ssrl_pkg::CMD_STB_Q: resp_data_nxt = widen(stb); // R11 R17
                ssrl_pkg::CMD_SRE_W: sre_nxt = I_CMD_DATA[7:0];
                ssrl_pkg::CMD_SRE_Q: resp_data_nxt = widen(sre_r); // R17
                ssrl_pkg::CMD_ESE_W: ese_nxt = I_CMD_DATA[7:0]; // R8
                ssrl_pkg::CMD_ESE_Q: resp_data_nxt = widen(ese_r); // R17
                ssrl_pkg::CMD_ESR_Q: begin
                    resp_data_nxt = widen(esr_r); // R17
                    esr_nxt = esr_set;
                end
                ssrl_pkg::CMD_PPE_W: ppe_nxt = I_CMD_DATA[7:0];
                ssrl_pkg::CMD_PPE_Q: resp_data_nxt = widen(ppe_r);
                ssrl_pkg::CMD_IST_Q: resp_data_nxt = {15'h0000, ist}; // R15
                ssrl_pkg::CMD_PPC_W: ppc_nxt = I_CMD_DATA[4:0]; // R14
                ssrl_pkg::CMD_PPC_Q: resp_data_nxt = {11'h000, ppc_r}; // R14
                ssrl_pkg::CMD_TCOND_Q: resp_data_nxt = tcond; // R17
                ssrl_pkg::CMD_TEVT_Q: begin
                    resp_data_nxt = tevt_r; // R17
                    tevt_nxt = tevt_set;
                end
                ssrl_pkg::CMD_TENA_W: tena_nxt = I_CMD_DATA & ssrl_pkg::TRAN_USED_MASK;
                ssrl_pkg::CMD_TENA_Q: resp_data_nxt = tena_r; // R17
                ssrl_pkg::CMD_ERR_Q: resp_data_nxt = errq.pop_code; // R19
                ssrl_pkg::CMD_OPC: opc_arm_nxt = !I_OPS_DONE;
                default: resp_data_nxt = ssrl_pkg::WORD_RESET;
            endcase
            // Arming and completion in one cycle flags at once
            if (cmd == ssrl_pkg::CMD_OPC && I_OPS_DONE) begin
                esr_nxt[ssrl_pkg::ESR_OPC] = 1'b1; // R8
            end
        end
    end

    // Power-on state: all enables and events clear, sweep running
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            sre_r <= ssrl_pkg::BYTE_RESET;
            ese_r <= ssrl_pkg::BYTE_RESET;
            ppe_r <= ssrl_pkg::BYTE_RESET;
            ppc_r <= ssrl_pkg::PPC_RESET;
            esr_r <= ssrl_pkg::BYTE_RESET;
            tena_r <= ssrl_pkg::WORD_RESET;
            tevt_r <= ssrl_pkg::WORD_RESET;
            range_r <= '0;
            opc_arm_r <= 1'b0;
            sweep_r <= ssrl_pkg::SWEEP_RUN;
            resume_r <= 1'b0;
            resp_valid_r <= 1'b0;
            resp_data_r <= ssrl_pkg::WORD_RESET;
            spoll_valid_r <= 1'b0;
            spoll_byte_r <= ssrl_pkg::BYTE_RESET;
        end else begin
            sre_r <= sre_nxt;
            ese_r <= ese_nxt;
            ppe_r <= ppe_nxt;
            ppc_r <= ppc_nxt;
            esr_r <= esr_nxt;
            tena_r <= tena_nxt;
            tevt_r <= tevt_nxt;
            range_r <= range_nxt;
            opc_arm_r <= opc_arm_nxt;
            sweep_r <= sweep_nxt;
            resume_r <= resume_nxt;
            resp_valid_r <= resp_valid_nxt;
            resp_data_r <= resp_data_nxt;
            spoll_valid_r <= spoll_valid_nxt;
            spoll_byte_r <= spoll_byte_nxt;
        end
    end

    assign O_RESP_VALID = resp_valid_r;
    assign O_RESP_DATA = resp_data_r;
    assign O_SWEEP_HOLD = (sweep_r == ssrl_pkg::SWEEP_HOLD);
    assign O_SWEEP_RESUME = resume_r;
    assign O_SPOLL_VALID = spoll_valid_r;
    assign O_SPOLL_BYTE = spoll_byte_r;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET);

    sequence s_hold_cont;
        O_SWEEP_HOLD && I_CMD_VALID && cmd == ssrl_pkg::CMD_CONT;
    endsequence
    sequence s_resumed;
        O_SWEEP_RESUME && !O_SWEEP_HOLD;
    endsequence

    a_range_flag_set: assert property (I_SUBRANGE_VALID && range_ok // R1
        |=> tcond[$past(I_SUBRANGE_NUM) - ssrl_pkg::RANGE_FIRST] && $onehot(range_r))
        else $error("subrange flag not set at its bit");
    a_hold_bit_shown: assert property (!O_SWEEP_HOLD && I_CHANGEOVER |=> tcond[ssrl_pkg::TRAN_HOLD_BIT]) // R2
        else $error("hold point bit missing");
    a_unused_bits_zero: assert property (((tcond | tevt_r) & ~ssrl_pkg::TRAN_USED_MASK) == 16'h0000) // R3
        else $error("unused status bits set");
    a_hold_then_resume: assert property (s_hold_cont |=> s_resumed ##1 !O_SWEEP_RESUME) // R4
        else $error("continue command did not resume sweep");
    a_srq_drops_clear: assert property (!summary(widen(stb & sre_r & ssrl_pkg::SRQ_SOURCE_MASK), 16'h00FF) // R21
        |-> !O_SRQ_OE)
        else $error("request held without enabled cause");
    a_esb_raises_srq: assert property (esr_r[ssrl_pkg::ESR_OPC] && ese_r[ssrl_pkg::ESR_OPC] // R9
        && sre_r[ssrl_pkg::STB_ESB] |-> O_SRQ_OE && stb[ssrl_pkg::STB_ESB])
        else $error("standard event did not raise request");
    a_spoll_byte: assert property (I_SPOLL_REQ |=> O_SPOLL_VALID && O_SPOLL_BYTE == $past(stb)) // R11
        else $error("serial poll byte mismatch");
    a_ist_reply: assert property (I_CMD_VALID && cmd == ssrl_pkg::CMD_IST_Q // R15
        |=> O_RESP_VALID && O_RESP_DATA == {15'h0000, $past(ist)})
        else $error("individual status reply mismatch");
endmodule // ssrl_top

// ---- ssrl_pkg.sv ----
// Constants, commands and states shared by the status and service request logic
package ssrl_pkg;

    // ********************************
    // Widths
    // ********************************
    localparam int STB_W = 8;
    localparam int DATA_W = 16;
    localparam int CODE_W = 16;
    localparam int CMD_W = 5;
    localparam int RANGE_NUM_W = 4;
    localparam int LINE_W = 3;

    // ********************************
    // Sweep subrange status register layout
    // ********************************
    localparam int TRAN_RANGES = 10;
    localparam int TRAN_HOLD_BIT = 14;
    localparam logic [15:0] TRAN_USED_MASK = 16'h43FF;
    localparam logic [3:0] RANGE_FIRST = 4'h1;
    localparam logic [3:0] RANGE_LAST = 4'hA;

    // ********************************
    // Status byte and standard event bit positions
    // ********************************
    localparam int STB_ERRQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;
    localparam int STB_OPER = 7;
    localparam logic [7:0] SRQ_SOURCE_MASK = 8'hBC;
    localparam int ESR_OPC = 0;
    localparam int ESR_DDE = 3;
    localparam int ESR_CME = 5;

    // ********************************
    // Parallel poll configuration fields
    // ********************************
    localparam int PPC_SENSE_BIT = 3;
    localparam int PPC_ENA_BIT = 4;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [4:0] PPC_RESET = 5'h00;
    localparam logic [15:0] ERR_NONE = 16'h0000;

    typedef enum logic [4:0] {
        CMD_STB_Q = 5'h00, CMD_SRE_W = 5'h01, CMD_SRE_Q = 5'h02, CMD_ESE_W = 5'h03,
        CMD_ESE_Q = 5'h04, CMD_ESR_Q = 5'h05, CMD_PPE_W = 5'h06, CMD_PPE_Q = 5'h07,
        CMD_IST_Q = 5'h08, CMD_PPC_W = 5'h09, CMD_TCOND_Q = 5'h0A, CMD_TEVT_Q = 5'h0B,
        CMD_TENA_W = 5'h0C, CMD_ERR_Q = 5'h0D, CMD_CONT = 5'h0E, CMD_OPC = 5'h0F,
        CMD_TENA_Q = 5'h10, CMD_PPC_Q = 5'h11
    } ssrl_cmd_t;

    typedef enum logic [0:0] {
        SWEEP_RUN = 1'b0,
        SWEEP_HOLD = 1'b1
    } ssrl_sweep_t;

endpackage

// ---- ssrl_errq_if.sv ----
// Push and pop signals between the status logic and its error queue
`timescale 1ns/1ps
interface ssrl_errq_if;
    logic push;
    logic [ssrl_pkg::CODE_W-1:0] push_code;
    logic pop;
    logic [ssrl_pkg::CODE_W-1:0] pop_code;
    logic empty;
    logic full;
    modport owner (output push, output push_code, output pop, input pop_code, input empty, input full);
    modport queue (input push, input push_code, input pop, output pop_code, output empty, output full);
endinterface // ssrl_errq_if

// ---- ssrl_errq.sv ----
// Fixed depth error queue, oldest entry first
`timescale 1ns/1ps
module ssrl_errq #(
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    ssrl_errq_if.queue q
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [ssrl_pkg::CODE_W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    // ********************************
    // Pointer and count update
    // ********************************
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == (AW)'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign q.empty = (cnt_r == '0);
    assign q.full = (cnt_r == DEPTH_C);
    // Empty queue answers with the no-error code
    assign q.pop_code = q.empty ? ssrl_pkg::ERR_NONE : mem[rd_r]; // R19

    // Full queue drops new errors; a pop in the same cycle frees a slot
    always_comb begin
        do_pop = q.pop && !q.empty; // R19
        do_push = q.push && (!q.full || do_pop); // R22
        wr_nxt = do_push ? ptr_inc(wr_r) : wr_r;
        rd_nxt = do_pop ? ptr_inc(rd_r) : rd_r;
        cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; only counted entries are ever read
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_r] <= q.push_code; // R18
        end
    end

    a_errq_empty_code: assert property (@(posedge clk) disable iff (rst) // R19
        q.pop && q.empty |-> q.pop_code == ssrl_pkg::ERR_NONE)
        else $error("empty queue pop did not return code zero");
    a_errq_full_keep: assert property (@(posedge clk) disable iff (rst) // R22
        q.full && q.push && !q.pop |=> q.full && $stable(rd_r) && $stable(wr_r))
        else $error("full queue accepted or lost an entry");
endmodule // ssrl_errq

// ---- ssrl_poll.sv ----
// Parallel poll response and individual status bit
`timescale 1ns/1ps
module ssrl_poll (
    input wire logic clk,
    input wire logic rst,
    input wire logic ppoll_pin,
    input wire logic [ssrl_pkg::STB_W-1:0] stb,
    input wire logic [ssrl_pkg::STB_W-1:0] ppe,
    input wire logic [ssrl_pkg::LINE_W-1:0] line,
    input wire logic invert,
    input wire logic enable,
    output logic ist,
    output logic [ssrl_pkg::STB_W-1:0] dio_out,
    output logic [ssrl_pkg::STB_W-1:0] dio_oe
);
    logic sync1_r, sync2_r;
    logic [ssrl_pkg::STB_W-1:0] out_r, out_nxt, oe_r, oe_nxt;

    // Enable mask ANDed with the whole status byte, bit 6 included, then ORed
    assign ist = |(ppe & stb); // R12

    // ********************************
    // Only the allocated line is driven, and only during the poll
    // ********************************
    always_comb begin
        out_nxt = '0;
        oe_nxt = '0;
        if (sync2_r && enable) begin
            oe_nxt[line] = 1'b1; // R13
            out_nxt[line] = ist ^ invert; // R12
        end
    end

    // Poll pin is asynchronous, so two stages before use
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            out_r <= '0;
            oe_r <= '0;
        end else begin
            sync1_r <= ppoll_pin;
            sync2_r <= sync1_r;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign dio_out = out_r;
    assign dio_oe = oe_r;

    a_dio_one_line: assert property (@(posedge clk) disable iff (rst) $onehot0(dio_oe)) // R13
        else $error("more than one data line driven");
    a_dio_value: assert property (@(posedge clk) disable iff (rst) // R12
        sync2_r && enable |=> dio_oe[$past(line)] && dio_out[$past(line)] == ($past(ist) ^ $past(invert)))
        else $error("poll response bit wrong");
endmodule // ssrl_poll

// ---- ssrl_ctrl_model.sv ----
// Bus controller model: serial poll and parallel poll on the instrument bus
`timescale 1ns/1ps
module ssrl_ctrl_model (
    input wire logic clk,
    input wire logic [7:0] dio_out,
    input wire logic [7:0] dio_oe,
    output logic ppoll_pin,
    output logic spoll_req,
    input wire logic spoll_valid,
    input wire logic [7:0] spoll_byte
);
    // ********************************
    // Poll sequences
    // ********************************
    // Released data lines float high through the bus pull-ups
    wire logic [7:0] dio_wire = (dio_out & dio_oe) | ~dio_oe;
    initial begin
        ppoll_pin = 1'b0;
        spoll_req = 1'b0;
    end
    // One request pulse, the byte is taken with its strobe
    task automatic spoll(output logic [7:0] b, output logic ok);
        int n;
        @(posedge clk);
        spoll_req <= 1'b1;
        @(posedge clk);
        spoll_req <= 1'b0;
        n = 0;
        #1;
        while (spoll_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = spoll_valid;
        b = spoll_byte;
    endtask
    // Caller configures line and sense first; pin held past the sync lag
    task automatic ppoll(output logic [7:0] w, output logic [7:0] oe);
        @(posedge clk);
        ppoll_pin <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        w = dio_wire;
        oe = dio_oe;
        @(posedge clk);
        ppoll_pin <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule // ssrl_ctrl_model

// ---- ssrl_top_bench.sv ----
// Self-checking bench of the status and service request logic
`timescale 1ns/1ps
module ssrl_top_bench;
    // ********************************
    // Stimulus, reference model and checks
    // ********************************
    logic clk, rst, cv, ev, eic, sv, chg, opsd, oav, oper, rv, hold, resume, spv, ppin, spq, srq_o, srq_oe;
    logic pul, b, ok;
    logic [4:0] cc;
    logic [15:0] cd, ec, rd, rsp;
    logic [3:0] sn;
    logic [7:0] spb, dout, doe, s, w, oe;
    logic [15:0] errs[$];
    int miscompares, tests_run, sre, ese, ppe, ten, tev, esr, r;
    ssrl_top #(.ERRQ_DEPTH(2)) i_ssrl_top (.I_CLOCK(clk), .I_RESET(rst), .I_CMD_VALID(cv), .I_CMD_CODE(cc),
        .I_CMD_DATA(cd), .O_RESP_VALID(rv), .O_RESP_DATA(rd), .I_ERR_VALID(ev), .I_ERR_IS_CMD(eic),
        .I_ERR_CODE(ec), .I_SUBRANGE_VALID(sv), .I_SUBRANGE_NUM(sn), .I_CHANGEOVER(chg), .O_SWEEP_HOLD(hold),
        .O_SWEEP_RESUME(resume), .I_OPS_DONE(opsd), .I_OUT_AVAIL(oav), .I_OPER_SUMMARY(oper), .I_SPOLL_REQ(spq),
        .O_SPOLL_VALID(spv), .O_SPOLL_BYTE(spb), .I_PPOLL_PIN(ppin), .O_SRQ_OUT(srq_o), .O_SRQ_OE(srq_oe),
        .O_DIO_OUT(dout), .O_DIO_OE(doe));
    ssrl_ctrl_model i_ssrl_ctrl_model (.clk(clk), .dio_out(dout), .dio_oe(doe), .ppoll_pin(ppin),
        .spoll_req(spq), .spoll_valid(spv), .spoll_byte(spb));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Expected status byte; bit 6 follows the enabled summaries
    function automatic logic [7:0] stb_m();
        logic [7:0] t;
        t = {oper, 1'b0, |(esr & ese), oav, |(tev & ten), errs.size() != 0, 2'b00};
        t[6] = |(t & sre[7:0] & 8'hBC);
        return t;
    endfunction
    // One command, reply awaited under a bound
    task automatic cmd(input logic [4:0] c, input logic [15:0] d);
        int n;
        @(posedge clk);
        cv <= 1'b1;
        cc <= c;
        cd <= d;
        @(posedge clk);
        cv <= 1'b0;
        n = 0;
        #1;
        while (rv !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (rv !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        rsp = rd;
        pul = resume;
    endtask
    // Event pulse: 0 subrange, 1 changeover, 2 device error, 3 command error
    task automatic strobe(input int k, input logic [15:0] v);
        @(posedge clk);
        sv <= k == 0;
        chg <= k == 1;
        ev <= k >= 2;
        eic <= k == 3;
        sn <= v[3:0];
        ec <= v;
        @(posedge clk);
        {sv, chg, ev} <= 3'b000;
        #1;
        if (k == 0) tev |= 1 << (v - 1);
        if (k == 1) tev |= 1 << 14;
        if (k >= 2) esr |= (k == 3) ? 32 : 8;
        if (k >= 2 && errs.size() < 2) errs.push_back(v);
    endtask
    task automatic vfy;
        s = stb_m();
        cmd(ssrl_pkg::CMD_STB_Q, 16'h0000);
        chk("status byte", {8'h00, s}, rsp);
        chk("service request", {15'h0000, s[6]}, {15'h0000, srq_oe});
    endtask
    initial begin
        r = $urandom(32'h603E0CB4);
        rst = 1'b1;
        {cv, ev, eic, sv, chg, opsd, cc, cd, ec, sn} = '0;
        {oav, oper} = r[1:0];
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        vfy();
        cmd(ssrl_pkg::CMD_SRE_W, 16'h00FF);
        cmd(ssrl_pkg::CMD_ESE_W, 16'h00FF);
        cmd(ssrl_pkg::CMD_TENA_W, 16'hFFFF);
        sre = 255;
        ese = 255;
        ten = 16'hFFFF;
        cmd(ssrl_pkg::CMD_SRE_Q, 16'h0000);
        chk("enable readback", 16'h00FF, rsp);
        cmd(ssrl_pkg::CMD_ESE_Q, 16'h0000);
        chk("event enable", 16'h00FF, rsp);
        cmd(ssrl_pkg::CMD_TENA_Q, 16'h0000);
        chk("sweep enable", 16'h43FF, rsp);
        // Ten randomly drawn subranges, repeats possible, each shown alone in the condition part
        for (int i = 0; i < 10; i++) begin
            r = $urandom_range(10, 1);
            strobe(0, r[15:0]);
            cmd(ssrl_pkg::CMD_TCOND_Q, 16'h0000);
            chk("sweep cond", 16'h0001 << (r - 1), rsp);
            vfy();
        end
        strobe(1, 16'h0000);
        chk("hold", 16'h0001, {15'h0000, hold});
        cmd(ssrl_pkg::CMD_TCOND_Q, 16'h0000);
        chk("cond top", 16'h4000, rsp & 16'hC000);
        cmd(ssrl_pkg::CMD_TEVT_Q, 16'h0000);
        chk("sweep event", tev[15:0], rsp);
        tev = 0;
        vfy();
        cmd(ssrl_pkg::CMD_CONT, 16'h0000);
        chk("resume", 16'h0001, {15'h0000, pul});
        chk("hold", 16'h0000, {15'h0000, hold});
        // Operation complete raising a request through the standard event summary
        cmd(ssrl_pkg::CMD_ESE_W, 16'h0001);
        cmd(ssrl_pkg::CMD_SRE_W, 16'h0020);
        ese = 1;
        sre = 32;
        @(posedge clk) opsd <= 1'b1;
        cmd(ssrl_pkg::CMD_OPC, 16'h0000);
        esr |= 1;
        @(posedge clk) opsd <= 1'b0;
        vfy();
        cmd(ssrl_pkg::CMD_ESR_Q, 16'h0000);
        chk("event status", esr[15:0], rsp);
        esr = 0;
        vfy();
        // Parallel and serial polls with random enables, line and sense
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            ppe = r[7:0];
            sre = ppe;
            cmd(ssrl_pkg::CMD_SRE_W, {8'h00, r[7:0]});
            cmd(ssrl_pkg::CMD_PPE_W, {8'h00, r[7:0]});
            cmd(ssrl_pkg::CMD_PPC_W, {11'h000, 1'b1, r[11:8]});
            s = stb_m();
            b = |(r[7:0] & s);
            cmd(ssrl_pkg::CMD_IST_Q, 16'h0000);
            chk("ist", {15'h0000, b}, rsp);
            cmd(ssrl_pkg::CMD_PPE_Q, 16'h0000);
            chk("poll mask", {8'h00, r[7:0]}, rsp);
            cmd(ssrl_pkg::CMD_PPC_Q, 16'h0000);
            chk("poll config", {11'h000, 1'b1, r[11:8]}, rsp);
            i_ssrl_ctrl_model.ppoll(w, oe);
            chk("poll enable", {8'h00, 8'h01 << r[10:8]}, {8'h00, oe});
            chk("poll line", {15'h0000, b ^ r[11]}, {15'h0000, w[r[10:8]]});
            chk("released", 16'h0000, {7'h00, srq_o, doe});
            i_ssrl_ctrl_model.spoll(w, ok);
            chk("serial poll", {8'h01, stb_m()}, {7'h00, ok, w});
        end
        // Three errors into a queue of two, then read past empty
        for (int i = 0; i < 3; i++) begin
            r = $urandom;
            strobe(2 + i % 2, r[15:0] | 16'h0001);
        end
        vfy();
        for (int i = 0; i < 3; i++) begin
            cmd(ssrl_pkg::CMD_ERR_Q, 16'h0000);
            chk("error entry", errs.size() ? errs.pop_front() : 16'h0000, rsp);
        end
        vfy();
        wrap_up();
    end
endmodule // ssrl_top_bench
